// ### hw/lgp_params.svh
// Constants for the LED greyscale PWM / trim core.
// Assumes one 100 MHz system clock; all pin inputs are asynchronous to it.
// Functional notes
// - Each of 16 channels holds its own 6-bit trim code, 64 settings.
// - Channel drive level scales with trim code: 0 is off, 63 full.
// - All trim codes load together from one serial packet.
// - Trim packet is 96 bits: sixteen 6-bit words.
// - Each channel has a 12-bit brightness code; it stays on for code-1 PWM clocks.
// - Brightness packet is 192 bits, sixteen 12-bit words, MSB first.
// - Mode input low selects brightness mode with a 192-bit shift register.
// - Load strobe rise in brightness mode latches all brightness codes at once.
// - Right after a brightness latch the shift register takes the status packet.
// - Status packet is only loaded while mode input is low.
// - Status is 192 bits; open-LED flags in bits 191:176 and 31:16.
// - Status bit 175 is overtemperature, bit 174 is temperature warning.
// - Status bits 167:72 hold the 96-bit trim register copy.
// - Status bits 15:0 are shorted-LED flags; other bits reserved, zero.
// - Status packet shifts out on the serial output with further shift clocks.
// - A PWM cycle begins on the falling edge of the blank input.
// - First PWM clock after blank falls advances counter, turns on channels with code 2 or more.
// - Every later PWM clock rising edge advances the counter by one, holding at 4095.
// - A channel turns off when its brightness code equals the counter.
// - Host raises blank after 4096 PWM clocks; counter then returns to zero.
// - Serial input is sampled on each rising shift clock edge not coinciding with a brightness latch.
// - Mode input high: load strobe rise updates trim registers instead.
// - Blank high forces all channels off and holds the counter at zero.
// - After reset: brightness mode, shift register cleared.
`ifndef LGP_PARAMS_SVH
`define LGP_PARAMS_SVH

`define LGP_CHANNELS        16
`define LGP_TRIM_BITS       6
`define LGP_BRIGHT_BITS     12
`define LGP_TRIM_PKT_BITS   96
`define LGP_BRIGHT_PKT_BITS 192

`define LGP_ST_OPEN_HI_LSB  176
`define LGP_ST_OVERTEMP     175
`define LGP_ST_TEMPWARN     174
`define LGP_ST_TRIM_LSB     72
`define LGP_ST_OPEN_LO_LSB  16
`define LGP_ST_SHORT_LSB    0

`define LGP_TRIM_RESET      96'h0
`define LGP_BRIGHT_RESET    192'h0
`define LGP_PWM_MAX         12'hfff

`define LGP_REG_CONTROL     4'h0
`define LGP_REG_STATUS      4'h4
`define LGP_REG_LATCHES     4'h8
`define LGP_CTRL_BLANK_BIT  0
`define LGP_STS_MODE_BIT    0
`define LGP_STS_BLANK_BIT   1
`define LGP_STS_RUN_BIT     2
`define LGP_STS_CNT_LSB     16

`endif

// ### hw/lgp_pkg.sv
// Types shared by the LED greyscale PWM / trim core.
// Assumes lgp_params.svh is compiled alongside.
package lgp_pkg;
  typedef enum logic [1:0] {
    PWM_BLANKED,
    PWM_ARMED,
    PWM_RUN
  } lgp_pwm_state_e;
endpackage

// ### hw/lgp_core.sv
// Digital core of a 16-channel LED sink driver: serial shift register,
// trim and brightness latches, status readback and greyscale PWM.
// Assumes pins are asynchronous to sys_clk_in and much slower than it.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "lgp_params.svh"

module lgp_core
  import lgp_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic          shift_clock_in,
  input  wire logic          serial_in,
  input  wire logic          mode_select_in,
  input  wire logic          load_strobe_in,
  input  wire logic          output_blank_in,
  input  wire logic          pwm_clock_in,
  input  wire logic [15:0]   open_led_in,
  input  wire logic [15:0]   short_led_in,
  input  wire logic          over_temp_in,
  input  wire logic          temp_warn_in,
  input  wire logic [3:0]    avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [31:0]   avs_writedata_in,
  input  wire logic [3:0]    avs_byteenable_in,
  output logic      [31:0]   avs_readdata_out,
  output logic               avs_waitrequest_out,
  output logic               serial_out,
  output logic      [15:0]   channel_sink_out,
  output logic      [95:0]   channel_level_out
);

  localparam int NSYNC = 40;

  // Status word layout, shared by the reload and its check
  function automatic logic [191:0] build_status(input logic [15:0] open_f,
                                                input logic [15:0] short_f,
                                                input logic        ot_f,
                                                input logic        tw_f,
                                                input logic [95:0] trim_f);
    logic [191:0] s;
    s = '0;
    s[`LGP_ST_OPEN_HI_LSB +: 16] = open_f;
    s[`LGP_ST_OPEN_LO_LSB +: 16] = open_f;
    s[`LGP_ST_OVERTEMP]          = ot_f;
    s[`LGP_ST_TEMPWARN]          = tw_f;
    s[`LGP_ST_TRIM_LSB +: 96]    = trim_f;
    s[`LGP_ST_SHORT_LSB +: 16]   = short_f;
    return s;
  endfunction

  // Brightness word of one channel
  function automatic logic [11:0] chan_code(input logic [191:0] b, input int n);
    return b[n*12 +: 12];
  endfunction

  // Two-stage synchroniser for every pin input
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  // Order must match the slices taken from sync_b below
  wire  [NSYNC-1:0] pins = {shift_clock_in,
                            serial_in,
                            mode_select_in,
                            load_strobe_in,
                            output_blank_in,
                            pwm_clock_in,
                            open_led_in,
                            short_led_in,
                            over_temp_in,
                            temp_warn_in};

  always_ff @(posedge sys_clk_in) begin
    sync_a <= pins;
    sync_b <= sync_a;
  end

  wire        sclk_s  = sync_b[39];
  wire        sdi_s   = sync_b[38];
  wire        mode_s  = sync_b[37];
  wire        ld_s    = sync_b[36];
  wire        blank_p = sync_b[35];
  wire        pclk_s  = sync_b[34];
  wire [15:0] open_s  = sync_b[33:18];
  wire [15:0] short_s = sync_b[17:2];
  wire        ot_s    = sync_b[1];
  wire        tw_s    = sync_b[0];

  // Bus-forced blank joins the pin before edge detection
  logic force_blank;
  wire  blank_s = blank_p | force_blank;

  // Edge detection on synchronised copies only
  logic sclk_d;
  logic ld_d;
  logic pclk_d;
  logic blank_d;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sclk_d  <= 1'b0;
      ld_d    <= 1'b0;
      pclk_d  <= 1'b0;
      blank_d <= 1'b1;
    end else begin
      sclk_d  <= sclk_s;
      ld_d    <= ld_s;
      pclk_d  <= pclk_s;
      blank_d <= blank_s;
    end
  end

  wire  sclk_rise = sclk_s & ~sclk_d;
  wire  ld_rise   = ld_s & ~ld_d;
  wire  pclk_rise = pclk_s & ~pclk_d;
  wire  blank_fall = ~blank_s & blank_d;

  // Shift register and latches
  logic [191:0] shift_reg;
  logic [191:0] bright;
  logic [95:0]  trim;
  logic [15:0]  latch_count;

  wire [191:0] status_word = build_status(open_s, short_s, ot_s, tw_s, trim);
  wire         gs_latch    = ld_rise & ~mode_s;
  wire         dc_latch    = ld_rise & mode_s;
  // Far end depends on mode: 96 bits in trim mode, 192 in brightness mode
  wire         far_bit     = mode_s ? shift_reg[`LGP_TRIM_PKT_BITS-1]
                                    : shift_reg[`LGP_BRIGHT_PKT_BITS-1];

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      shift_reg <= '0;
    end else if (gs_latch) begin
      shift_reg <= status_word;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[190:0], sdi_s};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bright      <= `LGP_BRIGHT_RESET;
      trim        <= `LGP_TRIM_RESET;
      latch_count <= 16'h0;
    end else if (gs_latch) begin
      bright      <= shift_reg;
      latch_count <= latch_count + 16'h1;
    end else if (dc_latch) begin
      trim        <= shift_reg[95:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= far_bit;
    end
  end

  // Greyscale PWM
  lgp_pwm_state_e pwm_state;
  lgp_pwm_state_e next_pwm_state;
  logic [11:0]    pwm_cnt;
  logic [11:0]    next_pwm_cnt;
  logic [15:0]    next_sink;

  always_comb begin
    next_pwm_state = pwm_state;
    next_pwm_cnt   = pwm_cnt;
    next_sink      = channel_sink_out;
    if (blank_s) begin
      next_pwm_state = PWM_BLANKED;
      next_pwm_cnt   = 12'h0;
      next_sink      = 16'h0;
    end else begin
      case (pwm_state)
        PWM_BLANKED: begin
          if (blank_fall) begin
            next_pwm_state = PWM_ARMED;
          end
        end
        PWM_ARMED: begin
          if (pclk_rise) begin
            next_pwm_state = PWM_RUN;
            next_pwm_cnt   = pwm_cnt + 12'h1;
            for (int i = 0; i < 16; i++) begin
              next_sink[i] = (chan_code(bright, i) != 12'h0) &&
                             (chan_code(bright, i) != next_pwm_cnt);
            end
          end
        end
        PWM_RUN: begin
          // Saturate so the cycle cannot restart before blank rises
          if (pclk_rise && pwm_cnt != `LGP_PWM_MAX) begin
            next_pwm_cnt = pwm_cnt + 12'h1;
            for (int i = 0; i < 16; i++) begin
              next_sink[i] = channel_sink_out[i] &&
                             (chan_code(bright, i) != next_pwm_cnt);
            end
          end
        end
        default: begin
          next_pwm_state = PWM_BLANKED;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pwm_state        <= PWM_BLANKED;
      pwm_cnt          <= 12'h0;
      channel_sink_out <= 16'h0;
    end else begin
      pwm_state        <= next_pwm_state;
      pwm_cnt          <= next_pwm_cnt;
      channel_sink_out <= next_sink;
    end
  end

  // Per-channel drive level; analog stage turns the code into current
  logic [95:0] next_level;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      next_level[i*6 +: 6] = next_sink[i] ? trim[i*6 +: 6] : 6'h0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      channel_level_out <= 96'h0;
    end else begin
      channel_level_out <= next_level;
    end
  end

  // Avalon-MM slave: one wait cycle, then the answer
  wire        bus_req  = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  wire        sel_ctrl = avs_address_in == `LGP_REG_CONTROL;
  wire        sel_sts  = avs_address_in == `LGP_REG_STATUS;
  wire        sel_lat  = avs_address_in == `LGP_REG_LATCHES;
  wire [31:0] sts_word = {4'h0, pwm_cnt, 13'h0, (pwm_state == PWM_RUN), blank_s, mode_s};
  wire [31:0] rd_mux   = sel_ctrl ? {31'h0, force_blank} :
                         sel_sts  ? sts_word :
                         sel_lat  ? {16'h0, latch_count} : 32'h0;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0;
      force_blank         <= 1'b0;
    end else if (bus_req) begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out    <= avs_read_in ? rd_mux : 32'h0;
      if (avs_write_in && sel_ctrl && avs_byteenable_in[0]) begin
        force_blank <= avs_writedata_in[`LGP_CTRL_BLANK_BIT];
      end
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  a_blank_forces_off: assert property (blank_s |=> channel_sink_out == 16'h0 && pwm_cnt == 12'h0)
    else $error("blank did not clear outputs and counter");

  a_first_pulse_on: assert property (pwm_state == PWM_ARMED && pclk_rise && !blank_s
    |=> pwm_cnt == 12'h1 && channel_sink_out[0] == ($past(bright[11:0]) > 12'h1))
    else $error("first pwm pulse wrong");

  a_count_advance: assert property (pwm_state == PWM_RUN && pclk_rise && !blank_s
    && pwm_cnt != 12'hfff |=> pwm_cnt == $past(pwm_cnt) + 12'h1)
    else $error("pwm counter did not advance");

  a_match_off: assert property (channel_sink_out[0] |-> bright[11:0] != pwm_cnt)
    else $error("channel on at matching count");

  a_bright_latch: assert property (gs_latch |=> bright == $past(shift_reg))
    else $error("brightness latch mismatch");

  a_status_reload: assert property (gs_latch
    |=> shift_reg == $past(status_word) && shift_reg[167:72] == trim)
    else $error("status packet not loaded");

  a_trim_latch: assert property (dc_latch
    |=> trim == $past(shift_reg[95:0]) && $stable(bright))
    else $error("trim latch mismatch");

  a_shift_sample: assert property (sclk_rise && !gs_latch
    |=> shift_reg[0] == $past(sdi_s) && shift_reg[191:1] == $past(shift_reg[190:0]))
    else $error("shift register did not sample");

  a_far_end: assert property (##1 serial_out == $past(far_bit))
    else $error("serial output not far end");

  a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer timing wrong");

  a_arm_on_fall: assert property (pwm_state == PWM_BLANKED && blank_fall
    |=> pwm_state == PWM_ARMED)
    else $error("blank fall did not arm pwm");

  a_armed_idle: assert property (pwm_state == PWM_ARMED && !pclk_rise && !blank_s
    |=> pwm_cnt == 12'h0 && channel_sink_out == 16'h0)
    else $error("outputs moved before first pwm pulse");

  a_blank_state: assert property (blank_s |=> pwm_state == PWM_BLANKED)
    else $error("pwm left blanked state while blank high");

  a_sink_stays_off: assert property (pwm_state == PWM_RUN && !blank_s
    && !channel_sink_out[2] |=> !channel_sink_out[2])
    else $error("channel came back on within a cycle");

  a_top_match_off: assert property (channel_sink_out[15]
    |-> chan_code(bright, 15) != pwm_cnt)
    else $error("top channel on at matching count");

  a_level_top: assert property (channel_level_out[95:90]
    == (channel_sink_out[15] ? $past(trim[95:90]) : 6'h0))
    else $error("top channel level wrong");

  a_level_low: assert property (channel_level_out[17:12]
    == (channel_sink_out[2] ? $past(trim[17:12]) : 6'h0))
    else $error("channel 2 level wrong");

  a_trim_no_reload: assert property (dc_latch && !sclk_rise
    |=> $stable(shift_reg))
    else $error("trim latch touched shift register");

  a_latch_count: assert property (gs_latch
    |=> latch_count == $past(latch_count) + 16'h1)
    else $error("latch count did not advance");

  a_far_trim: assert property (mode_s && sclk_rise ##1 mode_s
    |=> serial_out == $past(shift_reg[94], 2))
    else $error("trim mode far end wrong");

  a_far_bright: assert property (!mode_s && sclk_rise && !gs_latch ##1 !mode_s
    |=> serial_out == $past(shift_reg[190], 2))
    else $error("brightness mode far end wrong");

  a_status_open: assert property (gs_latch |=> shift_reg[191:176] == $past(open_s)
    && shift_reg[31:16] == $past(open_s))
    else $error("status open flags wrong");

  a_status_flags: assert property (gs_latch
    |=> shift_reg[175:174] == $past({ot_s, tw_s}) && shift_reg[15:0] == $past(short_s))
    else $error("status temperature or short flags wrong");

  a_reset_clears: assert property (disable iff (1'b0) rst_in
    |=> shift_reg == 192'h0 && serial_out == 1'b0 && channel_sink_out == 16'h0
    && pwm_state == PWM_BLANKED)
    else $error("reset did not clear state");

  a_read_unmapped: assert property (bus_req && avs_read_in && !sel_ctrl && !sel_sts && !sel_lat
    |=> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");

  a_ctrl_write: assert property (bus_req && avs_write_in && sel_ctrl && avs_byteenable_in[0]
    |=> force_blank == $past(avs_writedata_in[`LGP_CTRL_BLANK_BIT]))
    else $error("control write not taken");

  a_bus_idle: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
    |=> avs_waitrequest_out)
    else $error("waitrequest dropped without request");

endmodule

// ### testbench/lgp_host_model.sv
// Host model of the serial link: shift clock, data line and load strobe.
// Assumes sys_clk_in at 100 MHz; shift clock period is 8 of its cycles.
`timescale 1ns/10ps

module lgp_host_model (
  input  wire logic sys_clk_in,
  input  wire logic serial_out,
  output logic      shift_clock_out,
  output logic      serial_data_out,
  output logic      load_strobe_out
);
  initial begin
    shift_clock_out = 1'b0;
    serial_data_out = 1'b0;
    load_strobe_out = 1'b0;
  end

  // 80 ns shift clock (5 low, 3 high), above the cascade minimum
  task automatic shift_bits(input logic [191:0] d, input int n, output logic [191:0] rd);
    rd = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk_in);
      serial_data_out <= d[i];
      repeat (4) @(posedge sys_clk_in);
      rd[i] = serial_out;
      shift_clock_out <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      shift_clock_out <= 1'b0;
    end
    // Released line inverts so a stale bit cannot pass
    serial_data_out <= ~serial_data_out;
  endtask

  task automatic latch();
    @(posedge sys_clk_in);
    load_strobe_out <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    load_strobe_out <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
  endtask
endmodule

// ### testbench/tb_led_greyscale_pwm_dot_correction.sv
// Testbench for lgp_core: serial loads, status readback, PWM and bus.
// Assumes lgp_params.svh and lgp_pkg are compiled first.
`timescale 1ns/10ps
`include "lgp_params.svh"

module tb_led_greyscale_pwm_dot_correction;
  import lgp_pkg::*;
  typedef struct {int n; logic [15:0] sink;} lgp_row_s;
  logic         sys_clk_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         sclk, sdat, lds, serial_out;
  logic         mode = 1'b0;
  logic         blank = 1'b1;
  logic         pwm = 1'b0;
  logic         ot = 1'b1;
  logic         tw = 1'b0;
  logic [15:0]  open_l = 16'ha5c3;
  logic [15:0]  short_l = 16'h3c96;
  logic [3:0]   addr = 4'h0;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  rdat;
  logic         wait_r;
  logic [15:0]  sink;
  logic [95:0]  lvl;
  logic [191:0] trim, bri, q, st;
  logic [31:0]  bq;
  int           error_cnt = 0;
  int           compares = 0;
  int           cyc = 0;
  int           done = 0;
  lgp_row_s     rows[5] = '{'{1, 16'hfffc}, '{2, 16'hfff8}, '{5, 16'hffc0},
                            '{14, 16'h8000}, '{20, 16'h8000}};

  always #5 sys_clk_in = ~sys_clk_in;

  lgp_host_model i_lgp_host_model (.sys_clk_in(sys_clk_in), .serial_out(serial_out),
    .shift_clock_out(sclk), .serial_data_out(sdat), .load_strobe_out(lds));

  lgp_core i_lgp_core (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .shift_clock_in(sclk),
    .serial_in(sdat), .mode_select_in(mode), .load_strobe_in(lds),
    .output_blank_in(blank), .pwm_clock_in(pwm), .open_led_in(open_l),
    .short_led_in(short_l), .over_temp_in(ot), .temp_warn_in(tw),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r),
    .serial_out(serial_out), .channel_sink_out(sink), .channel_level_out(lvl));

  task automatic final_report();
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [191:0] got, input logic [191:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk_in);
    end while (wait_r !== 1'b0);
    bq = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Pulse spacing stands for a PWM clock far above 4096 x refresh
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      pwm <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      pwm <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
    end
    repeat (8) @(posedge sys_clk_in);
  endtask

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    trim = '0;
    bri = '0;
    for (int i = 0; i < 16; i++) begin
      trim[i*6 +: 6] = 6'(i * 4 + 3);
      bri[i*12 +: 12] = (i == 15) ? 12'hfff : 12'(i);
    end
    st = {open_l, 1'b1, 1'b0, 6'h0, trim[95:0], 40'h0, open_l, short_l};
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    chk(serial_out, 0, "reset serial_out");
    chk({sink, lvl}, 0, "reset outputs");
    bus(0, `LGP_REG_STATUS, 0);
    chk(bq[0], 0, "mode after reset");
    mode <= 1'b1;
    i_lgp_host_model.shift_bits(trim, 96, q);
    repeat (8) @(posedge sys_clk_in);
    chk(serial_out, trim[95], "trim far end");
    i_lgp_host_model.latch();
    chk(serial_out, trim[95], "trim latch reload");
    mode <= 1'b0;
    i_lgp_host_model.shift_bits(bri, 192, q);
    i_lgp_host_model.latch();
    i_lgp_host_model.shift_bits(192'h0, 192, q);
    chk(q, st, "status packet");
    ot <= 1'b0;
    tw <= 1'b1;
    i_lgp_host_model.shift_bits(bri, 192, q);
    i_lgp_host_model.latch();
    i_lgp_host_model.shift_bits(192'h0, 192, q);
    chk(q, st ^ {16'h0, 2'b11, 174'h0}, "status flags");
    bus(0, `LGP_REG_LATCHES, 0);
    chk(bq[15:0], 2, "latch count");
    blank <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    chk(sink, 0, "armed sinks");
    foreach (rows[r]) begin
      pulses(rows[r].n - done);
      done = rows[r].n;
      chk(sink, rows[r].sink, "sink pattern");
      for (int i = 0; i < 16; i++) begin
        chk(lvl[i*6 +: 6], rows[r].sink[i] ? trim[i*6 +: 6] : 6'h0, "level");
      end
      bus(0, `LGP_REG_STATUS, 0);
      chk(bq[27:16], 12'(done), "pwm count");
    end
    blank <= 1'b1;
    pulses(2);
    chk({sink, lvl}, 0, "blank outputs");
    bus(0, `LGP_REG_STATUS, 0);
    chk(bq[27:16], 0, "blank count");
    blank <= 1'b0;
    pulses(3);
    bus(1, `LGP_REG_CONTROL, 32'h1);
    repeat (8) @(posedge sys_clk_in);
    chk(sink, 0, "force blank");
    bus(0, `LGP_REG_CONTROL, 0);
    chk(bq[0], 1, "control readback");
    bus(0, 4'hc, 0);
    chk(bq, 0, "unmapped read");
    rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    chk({serial_out, sink}, 0, "second reset");
    bus(0, `LGP_REG_LATCHES, 0);
    chk(bq, 0, "latch count reset");
    final_report();
  end
endmodule
